/* File: rtl/jtag_pkg.sv */
// shared constants and types of the debug access port
`default_nettype none

package jtag_pkg;

  // ==========================================================
  // register sizes
  localparam int IR_W = 4;
  localparam int DR_W = 32;

  // ==========================================================
  // tap controller states
  typedef enum logic [3:0] {
    TAP_RESET    = 4'h0,
    TAP_IDLE     = 4'h1,
    TAP_SEL_DR   = 4'h3,
    TAP_CAP_DR   = 4'h2,
    TAP_SHIFT_DR = 4'h6,
    TAP_EX1_DR   = 4'h7,
    TAP_PAUSE_DR = 4'h5,
    TAP_EX2_DR   = 4'h4,
    TAP_UPD_DR   = 4'hC,
    TAP_SEL_IR   = 4'hD,
    TAP_CAP_IR   = 4'hF,
    TAP_SHIFT_IR = 4'hE,
    TAP_EX1_IR   = 4'hA,
    TAP_PAUSE_IR = 4'hB,
    TAP_EX2_IR   = 4'h9,
    TAP_UPD_IR   = 4'h8
  } tap_state_t;

  // ==========================================================
  // instructions
  localparam logic [IR_W-1:0] INS_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] INS_SAMPLE = 4'h1;
  localparam logic [IR_W-1:0] INS_IDCODE = 4'h2;
  localparam logic [IR_W-1:0] INS_USERCODE = 4'h3;
  localparam logic [IR_W-1:0] INS_CHIP = 4'h4;
  localparam logic [IR_W-1:0] INS_BYPASS = 4'hF;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] IR_RESET = INS_IDCODE;

  // ==========================================================
  // security word fields
  localparam int SEC_NO_JTAG = 0;
  localparam int SEC_NO_DEBUG = 14;
  localparam int SEC_UID_HI = 31;
  localparam int SEC_UID_LO = 22;
  localparam int UID_W = SEC_UID_HI - SEC_UID_LO + 1;
  localparam int UC_UNUSED_W = 4;
  localparam int UC_REV_W = 18;
  // synced copy: {no_jtag, user id}, refusing until first sample
  localparam logic [UID_W:0] SEC_SYNC_RST = 11'h400;

  // ==========================================================
  // debug pin mode and boot sequence
  typedef enum logic [1:0] {
    DBG_OFF  = 2'h0,
    DBG_OUT  = 2'h1,
    DBG_BOTH = 2'h3,
    DBG_IN   = 2'h2
  } dbg_mode_t;

  typedef enum logic [1:0] {
    BOOT_WAIT_LOCK = 2'h0,
    BOOT_START     = 2'h1,
    BOOT_RUN       = 2'h3
  } boot_state_t;

  localparam logic [1:0] BOOT_MODE_RST = 2'h0;

endpackage

`default_nettype wire

/* File: rtl/tap_ctrl_if.sv */
// state strobes from the tap controller to the scan registers
`default_nettype none

interface tap_ctrl_if;
  logic test_reset;
  logic capture_dr;
  logic shift_dr;
  logic update_dr;
  logic capture_ir;
  logic shift_ir;
  logic update_ir;

  modport fsm (
    output test_reset, capture_dr, shift_dr, update_dr,
    output capture_ir, shift_ir, update_ir
  );

  modport user (
    input test_reset, capture_dr, shift_dr, update_dr,
    input capture_ir, shift_ir, update_ir
  );
endinterface

`default_nettype wire

/* File: rtl/tap_fsm.sv */
// sixteen-state test access port controller
`default_nettype none

module tap_fsm (
  input wire logic i_tck,
  input wire logic i_trstn,
  input wire logic i_tms,
  tap_ctrl_if.fsm ctrl
);

  typedef struct packed {
    jtag_pkg::tap_state_t st;
  } fsm_t;

  fsm_t state_reg;
  fsm_t state_next;

  // ==========================================================
  // next state on mode select
  always_comb begin
    state_next = state_reg;
    unique case (state_reg.st)
      jtag_pkg::TAP_RESET:
        state_next.st = i_tms ? jtag_pkg::TAP_RESET : jtag_pkg::TAP_IDLE;
      jtag_pkg::TAP_IDLE:
        state_next.st = i_tms ? jtag_pkg::TAP_SEL_DR : jtag_pkg::TAP_IDLE;
      jtag_pkg::TAP_SEL_DR:
        state_next.st = i_tms ? jtag_pkg::TAP_SEL_IR : jtag_pkg::TAP_CAP_DR;
      jtag_pkg::TAP_CAP_DR:
        state_next.st = i_tms ? jtag_pkg::TAP_EX1_DR : jtag_pkg::TAP_SHIFT_DR;
      jtag_pkg::TAP_SHIFT_DR:
        state_next.st = i_tms ? jtag_pkg::TAP_EX1_DR : jtag_pkg::TAP_SHIFT_DR;
      jtag_pkg::TAP_EX1_DR:
        state_next.st = i_tms ? jtag_pkg::TAP_UPD_DR : jtag_pkg::TAP_PAUSE_DR;
      jtag_pkg::TAP_PAUSE_DR:
        state_next.st = i_tms ? jtag_pkg::TAP_EX2_DR : jtag_pkg::TAP_PAUSE_DR;
      jtag_pkg::TAP_EX2_DR:
        state_next.st = i_tms ? jtag_pkg::TAP_UPD_DR : jtag_pkg::TAP_SHIFT_DR;
      jtag_pkg::TAP_UPD_DR:
        state_next.st = i_tms ? jtag_pkg::TAP_SEL_DR : jtag_pkg::TAP_IDLE;
      jtag_pkg::TAP_SEL_IR:
        state_next.st = i_tms ? jtag_pkg::TAP_RESET : jtag_pkg::TAP_CAP_IR;
      jtag_pkg::TAP_CAP_IR:
        state_next.st = i_tms ? jtag_pkg::TAP_EX1_IR : jtag_pkg::TAP_SHIFT_IR;
      jtag_pkg::TAP_SHIFT_IR:
        state_next.st = i_tms ? jtag_pkg::TAP_EX1_IR : jtag_pkg::TAP_SHIFT_IR;
      jtag_pkg::TAP_EX1_IR:
        state_next.st = i_tms ? jtag_pkg::TAP_UPD_IR : jtag_pkg::TAP_PAUSE_IR;
      jtag_pkg::TAP_PAUSE_IR:
        state_next.st = i_tms ? jtag_pkg::TAP_EX2_IR : jtag_pkg::TAP_PAUSE_IR;
      jtag_pkg::TAP_EX2_IR:
        state_next.st = i_tms ? jtag_pkg::TAP_UPD_IR : jtag_pkg::TAP_SHIFT_IR;
      jtag_pkg::TAP_UPD_IR:
        state_next.st = i_tms ? jtag_pkg::TAP_SEL_DR : jtag_pkg::TAP_IDLE;
    endcase
  end

  // ==========================================================
  // state register, held in reset by test reset
  always_ff @(posedge i_tck or negedge i_trstn) begin
    if (!i_trstn) begin
      state_reg.st <= jtag_pkg::TAP_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // strobes for the scan registers
  assign ctrl.test_reset = (state_reg.st == jtag_pkg::TAP_RESET);
  assign ctrl.capture_dr = (state_reg.st == jtag_pkg::TAP_CAP_DR);
  assign ctrl.shift_dr = (state_reg.st == jtag_pkg::TAP_SHIFT_DR);
  assign ctrl.update_dr = (state_reg.st == jtag_pkg::TAP_UPD_DR);
  assign ctrl.capture_ir = (state_reg.st == jtag_pkg::TAP_CAP_IR);
  assign ctrl.shift_ir = (state_reg.st == jtag_pkg::TAP_SHIFT_IR);
  assign ctrl.update_ir = (state_reg.st == jtag_pkg::TAP_UPD_IR);

endmodule

`default_nettype wire

/* File: rtl/jtag_debug_access_port.sv */
// test and debug access port with boot sequencing and debug pin
`default_nettype none

module jtag_debug_access_port #(
  parameter logic [3:0] ID_VERSION = 4'h1, // arbitrary value
  parameter logic [15:0] ID_PART = 16'h0ABC, // arbitrary value
  parameter logic [10:0] ID_MAKER = 11'h155, // arbitrary value
  parameter logic [17:0] SILICON_REV = 18'h00001 // arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_pll_lock,
  input wire logic [1:0] i_boot_mode,
  output logic o_boot_start,
  output logic [1:0] o_boot_mode,
  output logic o_boot_done,
  input wire logic [31:0] i_sec_word,
  input wire logic [1:0] i_dbg_mode,
  input wire logic i_core_break,
  output logic o_core_debug_req,
  input wire logic i_debug_n_i,
  output logic o_debug_n_o,
  output logic o_debug_n_oe,
  input wire logic i_tck,
  input wire logic i_trstn,
  input wire logic i_tms,
  input wire logic i_tdi,
  output logic o_tdo,
  output logic o_tdo_oe,
  output logic o_scan_tdi,
  output logic o_chip_sel,
  output logic o_chip_reset,
  output logic o_chip_capture,
  output logic o_chip_shift,
  output logic o_chip_update,
  input wire logic i_chip_tdo,
  output logic o_bsr_extest,
  output logic o_bsr_sel,
  output logic o_bsr_capture,
  output logic o_bsr_shift,
  output logic o_bsr_update,
  input wire logic i_bsr_tdo
);

  // ==========================================================
  // state of the system clock domain
  typedef struct packed {
    logic lock_s1;
    logic lock_s2;
    logic dbg_s1;
    logic dbg_s2;
    logic dbg_d;
    jtag_pkg::boot_state_t boot;
    logic boot_start;
    logic [1:0] boot_mode;
    logic dbg_drive;
    logic [1:0] drv_hist;
    logic dbg_req;
  } sys_t;

  // ==========================================================
  // state of the test clock domain
  typedef struct packed {
    logic [jtag_pkg::UID_W:0] sec_s1;
    logic [jtag_pkg::UID_W:0] sec_s2;
    logic [jtag_pkg::IR_W-1:0] ir_sh;
    logic [jtag_pkg::IR_W-1:0] ir;
    logic [jtag_pkg::DR_W-1:0] dr;
    logic bypass;
  } tap_t;

  // ==========================================================
  // falling-edge output stage
  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } out_t;

  sys_t sys_reg;
  sys_t sys_next;
  tap_t tap_reg;
  tap_t tap_next;
  out_t out_reg;
  out_t out_next;

  tap_ctrl_if ctrl ();

  logic no_jtag;
  logic [jtag_pkg::UID_W-1:0] user_id;
  logic [jtag_pkg::DR_W-1:0] id_word;
  logic [jtag_pkg::DR_W-1:0] user_word;
  logic is_chip;
  logic is_bsr;
  logic is_data;
  logic chip_ok;
  logic dr_bit;
  logic out_mode;
  logic in_mode;
  logic dbg_blocked;
  logic dbg_fall;

  // ==========================================================
  // tap controller
  tap_fsm u_tap_fsm (
    .i_tck(i_tck),
    .i_trstn(i_trstn),
    .i_tms(i_tms),
    .ctrl(ctrl.fsm)
  );

  // ==========================================================
  // id and user code words returned by the data register, user id from the security word
  assign no_jtag = tap_reg.sec_s2[jtag_pkg::UID_W];
  assign user_id = tap_reg.sec_s2[jtag_pkg::UID_W-1:0];
  assign id_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  assign user_word = {user_id, {jtag_pkg::UC_UNUSED_W{1'b0}}, SILICON_REV};

  // ==========================================================
  // instruction decode
  assign is_chip = (tap_reg.ir == jtag_pkg::INS_CHIP);
  assign is_bsr = (tap_reg.ir == jtag_pkg::INS_EXTEST) ||
                  (tap_reg.ir == jtag_pkg::INS_SAMPLE);
  assign is_data = (tap_reg.ir == jtag_pkg::INS_IDCODE) ||
                   (tap_reg.ir == jtag_pkg::INS_USERCODE);
  assign chip_ok = is_chip && !no_jtag;

  // ==========================================================
  // test clock domain next state
  always_comb begin
    tap_next = tap_reg;
    tap_next.sec_s1 = {i_sec_word[jtag_pkg::SEC_NO_JTAG],
                       i_sec_word[jtag_pkg::SEC_UID_HI:jtag_pkg::SEC_UID_LO]};
    tap_next.sec_s2 = tap_reg.sec_s1;
    if (ctrl.capture_ir) begin
      tap_next.ir_sh = jtag_pkg::IR_CAPTURE;
    end else if (ctrl.shift_ir) begin
      tap_next.ir_sh = {i_tdi, tap_reg.ir_sh[jtag_pkg::IR_W-1:1]};
    end
    if (ctrl.test_reset) begin
      tap_next.ir = jtag_pkg::IR_RESET;
    end else if (ctrl.update_ir) begin
      tap_next.ir = tap_reg.ir_sh;
    end
    if (ctrl.capture_dr) begin
      tap_next.bypass = 1'b0;
      if (tap_reg.ir == jtag_pkg::INS_IDCODE) begin
        tap_next.dr = id_word;
      end else if (tap_reg.ir == jtag_pkg::INS_USERCODE) begin
        tap_next.dr = user_word;
      end
    end else if (ctrl.shift_dr) begin
      tap_next.bypass = i_tdi;
      tap_next.dr = {i_tdi, tap_reg.dr[jtag_pkg::DR_W-1:1]};
    end
  end

  // ==========================================================
  // test clock domain registers
  always_ff @(posedge i_tck or negedge i_trstn) begin
    if (!i_trstn) begin
      tap_reg.sec_s1 <= jtag_pkg::SEC_SYNC_RST;
      tap_reg.sec_s2 <= jtag_pkg::SEC_SYNC_RST;
      tap_reg.ir_sh <= jtag_pkg::IR_CAPTURE;
      tap_reg.ir <= jtag_pkg::IR_RESET;
      tap_reg.dr <= 32'h0000_0000;
      tap_reg.bypass <= 1'b0;
    end else begin
      tap_reg <= tap_next;
    end
  end

  // ==========================================================
  // serial output select
  always_comb begin
    if (is_data) begin
      dr_bit = tap_reg.dr[0];
    end else if (chip_ok) begin
      dr_bit = i_chip_tdo;
    end else if (is_bsr) begin
      dr_bit = i_bsr_tdo;
    end else begin
      dr_bit = tap_reg.bypass;
    end
    out_next.tdo = ctrl.shift_ir ? tap_reg.ir_sh[0] : dr_bit;
    out_next.tdo_oe = ctrl.shift_ir || ctrl.shift_dr;
  end

  // ==========================================================
  // output changes on the falling test clock edge
  always_ff @(negedge i_tck or negedge i_trstn) begin
    if (!i_trstn) begin
      out_reg.tdo <= 1'b0;
      out_reg.tdo_oe <= 1'b0;
    end else begin
      out_reg <= out_next;
    end
  end

  assign o_tdo = out_reg.tdo;
  assign o_tdo_oe = out_reg.tdo_oe;
  assign o_scan_tdi = i_tdi;

  // ==========================================================
  // chip-level port access
  assign o_chip_sel = chip_ok;
  assign o_chip_reset = ctrl.test_reset;
  assign o_chip_capture = ctrl.capture_dr && chip_ok;
  assign o_chip_shift = ctrl.shift_dr && chip_ok;
  assign o_chip_update = ctrl.update_dr && chip_ok;

  // ==========================================================
  // boundary scan chain of the pins
  assign o_bsr_extest = (tap_reg.ir == jtag_pkg::INS_EXTEST);
  assign o_bsr_sel = is_bsr;
  assign o_bsr_capture = ctrl.capture_dr && is_bsr;
  assign o_bsr_shift = ctrl.shift_dr && is_bsr;
  assign o_bsr_update = ctrl.update_dr && is_bsr;

  // ==========================================================
  // debug pin mode decode
  assign out_mode = (i_dbg_mode == jtag_pkg::DBG_OUT) ||
                    (i_dbg_mode == jtag_pkg::DBG_BOTH);
  assign in_mode = (i_dbg_mode == jtag_pkg::DBG_IN) ||
                   (i_dbg_mode == jtag_pkg::DBG_BOTH);
  assign dbg_blocked = i_sec_word[jtag_pkg::SEC_NO_DEBUG];
  assign dbg_fall = sys_reg.dbg_d && !sys_reg.dbg_s2;

  // ==========================================================
  // system clock domain next state
  always_comb begin
    sys_next = sys_reg;
    sys_next.lock_s1 = i_pll_lock;
    sys_next.lock_s2 = sys_reg.lock_s1;
    sys_next.dbg_s1 = i_debug_n_i;
    sys_next.dbg_s2 = sys_reg.dbg_s1;
    sys_next.dbg_d = sys_reg.dbg_s2;
    sys_next.boot_start = 1'b0;
    unique case (sys_reg.boot)
      jtag_pkg::BOOT_WAIT_LOCK: begin
        if (sys_reg.lock_s2) begin
          sys_next.boot = jtag_pkg::BOOT_START;
        end
      end
      jtag_pkg::BOOT_START: begin
        sys_next.boot_start = 1'b1;
        sys_next.boot_mode = i_boot_mode;
        sys_next.boot = jtag_pkg::BOOT_RUN;
      end
      jtag_pkg::BOOT_RUN: begin
        sys_next.boot = jtag_pkg::BOOT_RUN;
      end
      default: begin
        sys_next.boot = jtag_pkg::BOOT_WAIT_LOCK;
      end
    endcase
    sys_next.dbg_drive = out_mode && !dbg_blocked && i_core_break;
    // own drive echoes back through the synchroniser two cycles late
    sys_next.drv_hist = {sys_reg.drv_hist[0], sys_reg.dbg_drive};
    sys_next.dbg_req = in_mode && !dbg_blocked && !sys_reg.dbg_drive &&
                       (sys_reg.drv_hist == 2'h0) && dbg_fall;
  end

  // ==========================================================
  // system clock domain registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sys_reg.lock_s1 <= 1'b0;
      sys_reg.lock_s2 <= 1'b0;
      sys_reg.dbg_s1 <= 1'b1;
      sys_reg.dbg_s2 <= 1'b1;
      sys_reg.dbg_d <= 1'b1;
      sys_reg.boot <= jtag_pkg::BOOT_WAIT_LOCK;
      sys_reg.boot_start <= 1'b0;
      sys_reg.boot_mode <= jtag_pkg::BOOT_MODE_RST;
      sys_reg.dbg_drive <= 1'b0;
      sys_reg.drv_hist <= 2'h0;
      sys_reg.dbg_req <= 1'b0;
    end else begin
      sys_reg <= sys_next;
    end
  end

  // ==========================================================
  // system side outputs
  assign o_boot_start = sys_reg.boot_start;
  assign o_boot_mode = sys_reg.boot_mode;
  assign o_boot_done = (sys_reg.boot == jtag_pkg::BOOT_RUN);
  assign o_core_debug_req = sys_reg.dbg_req;
  assign o_debug_n_o = 1'b0;
  assign o_debug_n_oe = sys_reg.dbg_drive;

endmodule

`default_nettype wire

/* File: test/jtag_dap_props.sv */
// concurrent checks on the debug access port pins
`default_nettype none
module jtag_dap_props (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_pll_lock,
  input wire logic [31:0] i_sec_word,
  input wire logic [1:0] i_dbg_mode,
  input wire logic i_core_break,
  input wire logic i_debug_n_i,
  input wire logic i_trstn,
  input wire logic i_tdi,
  input wire logic o_boot_start,
  input wire logic o_boot_done,
  input wire logic o_core_debug_req,
  input wire logic o_debug_n_o,
  input wire logic o_debug_n_oe,
  input wire logic o_tdo_oe,
  input wire logic o_scan_tdi,
  input wire logic o_chip_sel,
  input wire logic o_chip_reset,
  input wire logic o_chip_shift,
  input wire logic o_bsr_shift
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // ==========================================================
  // debug pin
  AST_BREAK_DRIVE: assert property (
    i_core_break && i_dbg_mode[0] && !i_sec_word[14] |=> o_debug_n_oe) else $error("no drive");
  AST_PIN_FLOAT: assert property (
    !(i_core_break && i_dbg_mode[0]) |=> !o_debug_n_oe) else $error("pin not released");
  AST_DRAIN_LOW: assert property (
    o_debug_n_oe |-> !o_debug_n_o) else $error("pin driven high");
  AST_NO_DEBUG: assert property (
    i_sec_word[14] |-> !o_debug_n_oe && !o_core_debug_req) else $error("pin not blocked");
  AST_REQ_CAUSE: assert property (
    $fell(i_debug_n_i) && i_dbg_mode[1] && !i_sec_word[14] && !o_debug_n_oe
    |-> ##[1:5] o_core_debug_req) else $error("no debug request");
  AST_REQ_PULSE: assert property (
    o_core_debug_req |=> !o_core_debug_req) else $error("request too long");
  // ==========================================================
  // test port and boot
  AST_TRST_HOLD: assert property (
    !i_trstn |-> o_chip_reset && !o_tdo_oe && !o_chip_sel && !o_bsr_shift)
    else $error("test logic active in reset");
  AST_SEC_REFUSE: assert property (
    i_sec_word[0] |-> !o_chip_sel && !o_chip_shift) else $error("chip port not refused");
  AST_SCAN_PASS: assert property (
    o_scan_tdi == i_tdi) else $error("serial in not passed");
  AST_BOOT_WAIT: assert property (
    !i_pll_lock [*5] |-> !o_boot_start) else $error("boot without lock");
  AST_BOOT_ONCE: assert property (
    o_boot_start |-> o_boot_done ##1 !o_boot_start) else $error("boot pulse wrong");
  cover property (o_boot_start);
  cover property (o_core_debug_req);
  cover property (o_debug_n_oe);
  cover property (o_chip_shift);
endmodule
`default_nettype wire

/* File: test/jtag_host.sv */
// behavioural test-port host driving clock, reset, mode and serial data
`default_nettype none
module jtag_host (
  output logic o_tck,
  output logic o_trstn,
  output logic o_tms,
  output logic o_tdi,
  input wire logic i_tdo
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_tck = 1'b0;
    o_trstn = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // ==========================================================
  // one clock period, clock still between periods
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #16;
    tdo = i_tdo;
    o_tck = 1'b1;
    #16;
    o_tck = 1'b0;
  endtask
  task automatic reset_tap();
    logic d;
    o_trstn = 1'b0;
    #128;
    o_trstn = 1'b1;
    step(1'b0, 1'b0, d);
  endtask
  // from idle through capture, shift lsb first, update, back to idle
  task automatic scan(input logic is_ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic d;
    dout = 32'h0;
    step(1'b1, 1'b0, d);
    if (is_ir) step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
    step(1'b0, 1'b0, d);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], d);
      dout[i] = d;
    end
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
  endtask
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// self-checking bench for the debug access port
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] VER = 4'h3; // arbitrary value
  localparam logic [15:0] PART = 16'h1234; // arbitrary value
  localparam logic [10:0] MAKER = 11'h2A5; // arbitrary value
  localparam logic [17:0] REV = 18'h00002; // arbitrary value
  localparam logic [7:0] CAP = 8'h5A;
  logic clk, rstn, lock, brk, ext_low, tck, trstn, tms, tdi, tdo, oe, req, bstart, bdone;
  logic scan_in, chip_rst, c_cap, c_sh, b_cap, b_sh, dbg_pin_n, c_up, b_up, b_ext, b_sel;
  logic [1:0] bmode, bmode_o, mode;
  logic [31:0] sec, din, dout, seed;
  logic [7:0] chip_q = 8'h00;
  logic [7:0] bsr_q = 8'h00;
  logic [3:0] ins_q[$] = '{4'h2, 4'h3, 4'h4, 4'h0, 4'h1, 4'hF, 4'h9};
  int n_errors = 0;
  int cmp_count = 0;
  int n_cup = 0;
  int n_bup = 0;
  int n_ext = 0;
  int n, k, s, m;
  assign dbg_pin_n = ~(oe | ext_low);
  jtag_debug_access_port #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER),
    .SILICON_REV(REV)) DUT (
    .i_clk(clk), .i_rstn(rstn), .i_pll_lock(lock), .i_boot_mode(bmode),
    .o_boot_start(bstart), .o_boot_mode(bmode_o), .o_boot_done(bdone),
    .i_sec_word(sec), .i_dbg_mode(mode), .i_core_break(brk), .o_core_debug_req(req),
    .i_debug_n_i(dbg_pin_n), .o_debug_n_o(), .o_debug_n_oe(oe), .i_tck(tck),
    .i_trstn(trstn), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(),
    .o_scan_tdi(scan_in), .o_chip_sel(), .o_chip_reset(chip_rst), .o_chip_capture(c_cap),
    .o_chip_shift(c_sh), .o_chip_update(c_up), .i_chip_tdo(chip_q[0]), .o_bsr_extest(b_ext),
    .o_bsr_sel(b_sel), .o_bsr_capture(b_cap), .o_bsr_shift(b_sh), .o_bsr_update(b_up),
    .i_bsr_tdo(bsr_q[0]));
  jtag_host host (.o_tck(tck), .o_trstn(trstn), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo));
  // ==========================================================
  // chip port and boundary chain stand-ins, eight cells each
  always @(posedge tck) begin
    if (c_cap) chip_q <= CAP;
    else if (c_sh) chip_q <= {scan_in, chip_q[7:1]};
    if (b_cap) bsr_q <= ~CAP;
    else if (b_sh) bsr_q <= {scan_in, bsr_q[7:1]};
    if (c_up) n_cup <= n_cup + 1;
    if (b_up && b_sel) n_bup <= n_bup + 1;
    if (b_up && b_ext) n_ext <= n_ext + 1;
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ==========================================================
  // model of the scan path and checking
  function automatic logic [31:0] model(input logic [3:0] ins, input logic [31:0] sw,
                                        input logic [31:0] d);
    logic [31:0] w;
    int len;
    len = 1;
    w = 32'h0;
    case (ins)
      4'h2: begin len = 32; w = {VER, PART, MAKER, 1'b1}; end
      4'h3: begin len = 32; w = {sw[31:22], 4'h0, REV}; end
      4'h4: if (!sw[0]) begin len = 8; w = {24'h0, CAP}; end
      4'h0, 4'h1: begin len = 8; w = {24'h0, ~CAP}; end
      default: ;
    endcase
    return (len == 32) ? w : ((d << len) | w);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compares=%0d errors=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wait_boot();
    for (k = 0; bstart !== 1'b1; k++) begin
      if (k == 12) begin
        n_errors++;
        summarize();
      end
      @(negedge clk);
    end
    chk(bmode_o, bmode);
  endtask
  initial begin
    #400000;
    n_errors++;
    summarize();
  end
  // ==========================================================
  // main sequence
  initial begin
    seed = 32'h5CDB9C56;
    {rstn, lock, bmode, sec, mode, brk, ext_low} = '0;
    #24;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    repeat (20) @(negedge clk);
    chk(bdone, 1'b0);
    bmode = 2'($random(seed));
    lock = 1'b1;
    wait_boot();
    @(negedge clk) chk(bdone, 1'b1);
    #2 rstn = 1'b0;
    #1 chk(bdone, 1'b0);
    repeat (13) @(negedge clk);
    rstn = 1'b1;
    bmode = 2'($random(seed));
    wait_boot();
    for (s = 0; s < 2; s++) begin
      sec[14] = s[0];
      for (m = 0; m < 4; m++) begin
        @(negedge clk) mode = 2'(m);
        brk = 1'b1;
        @(negedge clk) chk(oe, m[0] & ~s[0]);
        brk = 1'b0;
        @(negedge clk) chk(oe, 1'b0);
        n = int'(req);
        repeat (4) @(negedge clk) n += int'(req);
        chk(32'(n), 32'h0000_0000);
        ext_low = 1'b1;
        n = 0;
        repeat (8) @(negedge clk) n += req;
        ext_low = 1'b0;
        repeat (4) @(negedge clk);
        chk(32'(n), {31'h0, m[1] & ~s[0]});
      end
    end
    for (s = 0; s < 2; s++) begin
      sec = s[0] ? (($random(seed) | 32'h0000_0001) & 32'hFFFF_BFFF) : 32'h0000_0000;
      fork
        host.reset_tap();
        #64 chk(chip_rst, 1'b1);
      join
      din = $random(seed);
      host.scan(1'b0, 32, din, dout);
      chk(dout, model(4'h2, sec, din));
      foreach (ins_q[i]) begin
        host.scan(1'b1, 4, {28'h0, ins_q[i]}, dout);
        chk(dout, 32'h1);
        din = $random(seed);
        host.scan(1'b0, 32, din, dout);
        chk(dout, model(ins_q[i], sec, din));
      end
    end
    chk(32'(n_cup), 32'h0000_0001);
    chk(32'(n_bup), 32'h0000_0004);
    chk(32'(n_ext), 32'h0000_0002);
    summarize();
  end
endmodule
bind jtag_debug_access_port jtag_dap_props props (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_pll_lock(i_pll_lock), .i_sec_word(i_sec_word),
  .i_dbg_mode(i_dbg_mode), .i_core_break(i_core_break), .i_debug_n_i(i_debug_n_i),
  .i_trstn(i_trstn), .i_tdi(i_tdi), .o_boot_start(o_boot_start), .o_boot_done(o_boot_done),
  .o_core_debug_req(o_core_debug_req), .o_debug_n_o(o_debug_n_o),
  .o_debug_n_oe(o_debug_n_oe), .o_tdo_oe(o_tdo_oe), .o_scan_tdi(o_scan_tdi),
  .o_chip_sel(o_chip_sel), .o_chip_reset(o_chip_reset), .o_chip_shift(o_chip_shift),
  .o_bsr_shift(o_bsr_shift));
`default_nettype wire
